/* bswm_pkg.sv */
// package: constants and types for the burst sram lane write mask block
// How it works
// - selects may change between beats of burst
// - x8 both half selects low: write 7:0
// - x8 low half only: write 3:0, keep 7:4
// - x8 high half only: write 7:4, keep 3:0
// - x18 both lane selects low: write 17:0
// - x18 lane0 only: write 8:0, keep 17:9
// - x18 lane1 only: write 17:9, keep 8:0
// - all selects high: location left unchanged
// - x9 single select: low writes 8:0, high nothing
// - x36 all four low: write 35:0
// - x36 lane0 only: write 8:0
// - x36 lane1 only: write 17:9
// - x36 lane2 only: write 26:18
// - x36 lane3 only: write 35:27
// - write load at t, beats at t+2,t+3; a load in the second data cycle gets beats at t+1,t+2
// - every beat samples its own lane selects
package bswm_pkg;
    localparam int BEATS       = 4;   // words per burst
    localparam int BEAT_W      = 2;   // beat index width
    localparam int NIBBLE_W    = 4;   // lane width in the 8-bit variant
    localparam int BYTE_W      = 9;   // lane width in the 9/18/36-bit variants
    localparam int WIDTH_X8    = 8;   // variant widths
    localparam int WIDTH_X9    = 9;
    localparam int WIDTH_X18   = 18;
    localparam int WIDTH_X36   = 36;
    localparam int LANES_MAX   = 4;   // most select inputs of any variant
    localparam logic [1:0] BURST_START_ZERO = 2'h0; // x8/x9 bursts start at zero
    // burst phase: idle, waiting cycle t+1, then two data cycles
    typedef enum logic [1:0] {BSWM_IDLE, BSWM_WAIT, BSWM_DATA1, BSWM_DATA2} bswm_state_t;
endpackage

/* bswm_write_mask.sv */
// design: per-beat lane write mask and array for a ddr burst sram write path
`timescale 1ns/1ps
module bswm_write_mask #(
    parameter int DATA_W = bswm_pkg::WIDTH_X18, // 8, 9, 18 or 36
    parameter int ADDR_W = 6                    // word address width, small default
) (
    input  wire logic              clk,            // system clock, 40 MHz
    input  wire logic              srst,           // synchronous reset, active high
    input  wire logic              load_select_n,  // pin: load address, active low
    input  wire logic              read_write_n,   // pin: high read, low write
    input  wire logic [ADDR_W-1:0] addr,           // pin: burst start address
    input  wire logic [DATA_W-1:0] wdata_k,        // pin: beat data at true clock rise
    input  wire logic [DATA_W-1:0] wdata_kn,       // pin: beat data at compl clock rise
    input  wire logic [3:0]        sel_n_k,        // pin: lane selects with true beat
    input  wire logic [3:0]        sel_n_kn,       // pin: lane selects with compl beat
    input  wire logic [ADDR_W-1:0] rd_addr,        // inspection read address
    output logic      [DATA_W-1:0] rd_data,        // stored word, one cycle later
    output logic                   write_active,   // a data cycle of a write burst
    output logic      [3:0]        beat_written    // pulse: beat stored, per beat index
);
    // lane count and lane width follow the variant
    localparam int LANE_W = (DATA_W == bswm_pkg::WIDTH_X8) ? bswm_pkg::NIBBLE_W
                                                           : bswm_pkg::BYTE_W;
    localparam int LANES  = DATA_W / LANE_W;
    localparam int DEPTH  = 1 << ADDR_W;
    // lane indices folded to zero where the variant lacks that lane, so slices stay in range
    localparam int L1     = (LANES > 1) ? 1 : 0;
    localparam int L2     = (LANES > 2) ? 2 : 0;
    localparam int L3     = (LANES > 3) ? 3 : 0;

    // refuse widths the lane slicing cannot serve
    initial begin
        if (DATA_W != bswm_pkg::WIDTH_X8 && DATA_W != bswm_pkg::WIDTH_X9 &&
            DATA_W != bswm_pkg::WIDTH_X18 && DATA_W != bswm_pkg::WIDTH_X36) begin
            $error("bswm_write_mask: unsupported DATA_W");
        end
        if (ADDR_W < bswm_pkg::BEAT_W) begin
            $error("bswm_write_mask: ADDR_W too small");
        end
        // the select ports carry at most four lanes
        if (LANES > bswm_pkg::LANES_MAX) begin
            $error("bswm_write_mask: too many lanes");
        end
    end

    // pin synchronisers: two flops before any logic reads a pin
    logic              ld_n_m_q, ld_n_q;
    logic              rw_n_m_q, rw_n_q;
    logic [ADDR_W-1:0] a_m_q, a_q;
    logic [DATA_W-1:0] dk_m_q, dk_q, dkn_m_q, dkn_q;
    logic [3:0]        sk_m_q, sk_q, skn_m_q, skn_q;

    // every pin takes the same two-stage delay, so beat data and its selects stay paired
    always_ff @(posedge clk) begin
        ld_n_m_q <= load_select_n;
        ld_n_q   <= ld_n_m_q;
        rw_n_m_q <= read_write_n;
        rw_n_q   <= rw_n_m_q;
        a_m_q    <= addr;
        a_q      <= a_m_q;
        dk_m_q   <= wdata_k;
        dk_q     <= dk_m_q;
        dkn_m_q  <= wdata_kn;
        dkn_q    <= dkn_m_q;
        sk_m_q   <= sel_n_k;
        sk_q     <= sk_m_q;
        skn_m_q  <= sel_n_kn;
        skn_q    <= skn_m_q;
    end

    // burst sequencer state
    bswm_pkg::bswm_state_t state_q, state_d;
    logic [ADDR_W-1:0]     base_q, base_d;     // latched start address

    // a write is loaded with both controls low; a new load can follow the last data cycle
    wire logic wr_load = !ld_n_q && !rw_n_q;

    // next state of the burst sequencer
    always_comb begin
        state_d = state_q;
        base_d  = base_q;
        case (state_q)
            bswm_pkg::BSWM_IDLE: begin
                if (wr_load) begin
                    state_d = bswm_pkg::BSWM_WAIT;
                    base_d  = a_q;
                end
            end
            bswm_pkg::BSWM_WAIT:  state_d = bswm_pkg::BSWM_DATA1; // data at t+2
            bswm_pkg::BSWM_DATA1: state_d = bswm_pkg::BSWM_DATA2; // data at t+3
            bswm_pkg::BSWM_DATA2: begin
                // back-to-back write: the load sits in the second data cycle
                if (wr_load) begin
                    state_d = bswm_pkg::BSWM_DATA1;
                    base_d  = a_q;
                end else begin
                    state_d = bswm_pkg::BSWM_IDLE;
                end
            end
            default: state_d = bswm_pkg::BSWM_IDLE;
        endcase
    end

    // register the sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= bswm_pkg::BSWM_IDLE;
            base_q  <= '0;
        end else begin
            state_q <= state_d;
            base_q  <= base_d;
        end
    end

    // data cycle flags; the wait state reloads from idle only
    wire logic in_d1 = (state_q == bswm_pkg::BSWM_DATA1);
    wire logic in_d2 = (state_q == bswm_pkg::BSWM_DATA2);

    // burst address of each beat: x8/x9 start at zero, wider ones wrap from the low bits
    logic [bswm_pkg::BEAT_W-1:0] start_off;
    logic [bswm_pkg::BEAT_W-1:0] off_a, off_b;
    always_comb begin
        if (DATA_W <= bswm_pkg::WIDTH_X9) begin
            start_off = bswm_pkg::BURST_START_ZERO;
        end else begin
            start_off = base_q[bswm_pkg::BEAT_W-1:0];
        end
        // first data cycle carries beats 0 and 1, second beats 2 and 3
        off_a = start_off + (in_d2 ? 2'h2 : 2'h0);
        off_b = start_off + (in_d2 ? 2'h3 : 2'h1);
    end
    wire logic [ADDR_W-1:0] addr_a = {base_q[ADDR_W-1:bswm_pkg::BEAT_W], off_a};
    wire logic [ADDR_W-1:0] addr_b = {base_q[ADDR_W-1:bswm_pkg::BEAT_W], off_b};

    // per-beat bit enables from the selects sampled with that very beat
    logic [DATA_W-1:0] en_a, en_b;
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            // a low select writes its lane; high keeps it, so all high writes nothing
            en_a[i] = !sk_q[i / LANE_W];
            en_b[i] = !skn_q[i / LANE_W];
        end
    end

    // storage array; masked bits keep their old contents
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DATA_W-1:0] rd_data_q;
    logic [3:0]        wr_beat_q, wr_beat_d;

    // which beat indices are stored in this cycle
    always_comb begin
        wr_beat_d = '0;
        if (in_d1) begin
            wr_beat_d[0] = |en_a;
            wr_beat_d[1] = |en_b;
        end else if (in_d2) begin
            wr_beat_d[2] = |en_a;
            wr_beat_d[3] = |en_b;
        end
    end

    // bitwise merge of beat data into the addressed words
    always_ff @(posedge clk) begin
        if (in_d1 || in_d2) begin
            for (int i = 0; i < DATA_W; i++) begin
                if (en_a[i]) begin
                    mem_q[addr_a][i] <= dk_q[i];
                end
                if (en_b[i]) begin
                    mem_q[addr_b][i] <= dkn_q[i];
                end
            end
        end
    end

    // registered read port and beat pulses
    always_ff @(posedge clk) begin
        rd_data_q <= mem_q[rd_addr];
        if (srst) begin
            wr_beat_q <= '0;
        end else begin
            wr_beat_q <= wr_beat_d;
        end
    end

    assign rd_data      = rd_data_q;
    assign beat_written = wr_beat_q;
    assign write_active = in_d1 || in_d2;

    // checks
    property p_burst_timing;
        @(posedge clk) disable iff (srst)
        (state_q == bswm_pkg::BSWM_IDLE && wr_load) |=> !write_active ##1 in_d1 ##1 in_d2;
    endproperty
    a_burst_timing: assert property (p_burst_timing) else $error("burst data cycles misplaced");

    property p_all_high_no_write;
        @(posedge clk) disable iff (srst)
        (in_d1 && sk_q == 4'hF) |=> !beat_written[0];
    endproperty
    a_all_high_no_write: assert property (p_all_high_no_write) else $error("masked beat stored");

    property p_low_select_writes;
        @(posedge clk) disable iff (srst)
        (in_d2 && !skn_q[0]) |=> beat_written[3];
    endproperty
    a_low_select_writes: assert property (p_low_select_writes) else $error("beat not stored");

    property p_lane0_stored;
        @(posedge clk) disable iff (srst)
        (in_d1 && !sk_q[0] && rd_addr == addr_a && !(addr_b == addr_a && !skn_q[0]))
        |=> ##1 (rd_data[LANE_W-1:0] == $past(dk_q[LANE_W-1:0], 2));
    endproperty
    a_lane0_stored: assert property (p_lane0_stored) else $error("lane 0 not written");

    property p_lane0_kept;
        @(posedge clk) disable iff (srst)
        (in_d1 && sk_q[0] && skn_q[0] && $stable(rd_addr) && rd_addr == addr_a)
        |=> (mem_q[$past(addr_a)][LANE_W-1:0] == $past(mem_q[addr_a][LANE_W-1:0]));
    endproperty
    a_lane0_kept: assert property (p_lane0_kept) else $error("masked lane changed");

    property p_no_write_idle;
        @(posedge clk) disable iff (srst)
        !write_active |=> beat_written == 4'h0;
    endproperty
    a_no_write_idle: assert property (p_no_write_idle) else $error("write outside burst");

    property p_beat_pair;
        @(posedge clk) disable iff (srst)
        in_d1 |=> in_d2;
    endproperty
    a_beat_pair: assert property (p_beat_pair) else $error("second data cycle lost");

    property p_addr_wrap;
        @(posedge clk) disable iff (srst)
        write_active |-> addr_b[bswm_pkg::BEAT_W-1:0] == 2'(addr_a[bswm_pkg::BEAT_W-1:0] + 2'h1);
    endproperty
    a_addr_wrap: assert property (p_addr_wrap) else $error("beat address order wrong");

    // lane-level checks below read the array one edge after the merge; the two beats of a
    // data cycle always address different words, so neither can hide the other

    property p_odd_masked_no_write;
        @(posedge clk) disable iff (srst)
        (in_d2 && &skn_q[LANES-1:0]) |=> !beat_written[3];
    endproperty
    a_odd_masked_no_write: assert property (p_odd_masked_no_write) else $error("masked beat stored");

    property p_even_any_lane_writes;
        @(posedge clk) disable iff (srst)
        (in_d1 && !(&sk_q[LANES-1:0])) |=> beat_written[0];
    endproperty
    a_even_any_lane_writes: assert property (p_even_any_lane_writes) else $error("beat lost");

    property p_full_word_stored;
        @(posedge clk) disable iff (srst)
        (in_d1 && sk_q[LANES-1:0] == '0) |=> mem_q[$past(addr_a)] == $past(dk_q);
    endproperty
    a_full_word_stored: assert property (p_full_word_stored) else $error("word not written");

    property p_word_kept;
        @(posedge clk) disable iff (srst)
        (in_d2 && &skn_q[LANES-1:0]) |=> mem_q[$past(addr_b)] == $past(mem_q[addr_b]);
    endproperty
    a_word_kept: assert property (p_word_kept) else $error("masked word changed");

    property p_lane1_stored;
        @(posedge clk) disable iff (srst)
        (LANES > 1 && in_d2 && !skn_q[L1])
        |=> mem_q[$past(addr_b)][L1*LANE_W +: LANE_W] == $past(dkn_q[L1*LANE_W +: LANE_W]);
    endproperty
    a_lane1_stored: assert property (p_lane1_stored) else $error("lane 1 not written");

    property p_lane1_kept;
        @(posedge clk) disable iff (srst)
        (LANES > 1 && in_d2 && skn_q[L1])
        |=> mem_q[$past(addr_b)][L1*LANE_W +: LANE_W] == $past(mem_q[addr_b][L1*LANE_W +: LANE_W]);
    endproperty
    a_lane1_kept: assert property (p_lane1_kept) else $error("lane 1 changed");

    property p_lane2_stored;
        @(posedge clk) disable iff (srst)
        (LANES > 2 && in_d2 && !skn_q[L2])
        |=> mem_q[$past(addr_b)][L2*LANE_W +: LANE_W] == $past(dkn_q[L2*LANE_W +: LANE_W]);
    endproperty
    a_lane2_stored: assert property (p_lane2_stored) else $error("lane 2 not written");

    property p_lane3_stored;
        @(posedge clk) disable iff (srst)
        (LANES > 3 && in_d1 && !sk_q[L3])
        |=> mem_q[$past(addr_a)][L3*LANE_W +: LANE_W] == $past(dk_q[L3*LANE_W +: LANE_W]);
    endproperty
    a_lane3_stored: assert property (p_lane3_stored) else $error("lane 3 not written");

    property p_top_lane_stored;
        @(posedge clk) disable iff (srst)
        (in_d1 && !sk_q[LANES-1])
        |=> mem_q[$past(addr_a)][DATA_W-1 -: LANE_W] == $past(dk_q[DATA_W-1 -: LANE_W]);
    endproperty
    a_top_lane_stored: assert property (p_top_lane_stored) else $error("top lane not written");
endmodule

/* bswm_ctl_model.sv */
// partner: memory controller model that frames write bursts on the device pins
`timescale 1ns/1ps
module bswm_ctl_model (
    input  wire logic        clk,           // system clock
    output logic             load_select_n, // burst load, active low
    output logic             read_write_n,  // low means write at load
    output logic [5:0]       addr,          // burst start address
    output logic [35:0]      wdata_k,       // even beat data
    output logic [35:0]      wdata_kn,      // odd beat data
    output logic [3:0]       sel_n_k,       // even beat lane selects
    output logic [3:0]       sel_n_kn       // odd beat lane selects
);
    // pins start deselected so no load is seen before the first burst
    initial begin
        load_select_n = 1'b1;
        read_write_n  = 1'b1;
        addr          = 6'h00;
        wdata_k       = 36'h0;
        wdata_kn      = 36'h0;
        sel_n_k       = 4'hF;
        sel_n_kn      = 4'hF;
    end
    // load at t, wait at t+1, beats 0/1 at t+2 and beats 2/3 at t+3; selects differ per beat
    task automatic burst(input logic [5:0] a, input logic rw,
                         input logic [35:0] d [4], input logic [3:0] s [4]);
        @(posedge clk);
        load_select_n <= 1'b0;
        read_write_n  <= rw;
        addr          <= a;
        @(posedge clk);
        load_select_n <= 1'b1;
        read_write_n  <= ~rw;  // released pins show junk, not the old value
        addr          <= ~a;
        @(posedge clk);
        wdata_k       <= d[0];
        wdata_kn      <= d[1];
        sel_n_k       <= s[0];
        sel_n_kn      <= s[1];
        @(posedge clk);
        wdata_k       <= d[2];
        wdata_kn      <= d[3];
        sel_n_k       <= s[2];
        sel_n_kn      <= s[3];
        @(posedge clk);
        wdata_k       <= ~d[2]; // hold time over: inverse of last value
        wdata_kn      <= ~d[3];
        sel_n_k       <= ~s[2];
        sel_n_kn      <= ~s[3];
    endtask
endmodule

/* burst_sram_byte_write_mask_test.sv */
// testbench: random masked write bursts on the widest variant, checked against a model
`timescale 1ns/1ps
module burst_sram_byte_write_mask_test;
    logic        clk;          // 40 MHz clock
    logic        srst;         // sync reset
    logic        ld_n;         // load, active low
    logic        rw_n;         // read or write
    logic [5:0]  addr;         // burst address
    logic [35:0] wk;           // even beat data
    logic [35:0] wkn;          // odd beat data
    logic [3:0]  sk;           // even beat selects
    logic [3:0]  skn;          // odd beat selects
    logic [5:0]  rd_addr;      // inspection address
    logic [35:0] rd_data;      // stored word
    logic        write_active; // data cycle flag
    logic [3:0]  beat_written; // per-beat store pulse
    logic [35:0] mem_m [64];   // expected array contents
    int          mismatches;
    int          tests_run;

    bswm_ctl_model u_ctl (.clk(clk), .load_select_n(ld_n), .read_write_n(rw_n), .addr(addr),
        .wdata_k(wk), .wdata_kn(wkn), .sel_n_k(sk), .sel_n_kn(skn));
    bswm_write_mask #(.DATA_W(bswm_pkg::WIDTH_X36), .ADDR_W(6)) DUT (.clk(clk), .srst(srst),
        .load_select_n(ld_n), .read_write_n(rw_n), .addr(addr), .wdata_k(wk), .wdata_kn(wkn),
        .sel_n_k(sk), .sel_n_kn(skn), .rd_addr(rd_addr), .rd_data(rd_data),
        .write_active(write_active), .beat_written(beat_written));

    // free-running clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // data word compare
    task automatic chk_d(input string n, input logic [35:0] e, input logic [35:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // status compare: write_active in bit 0, or beat_written
    task automatic chk_s(input string n, input logic [3:0] e, input logic [3:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // one burst with model update and checks; full forces all lanes written
    task automatic run(input logic [5:0] a, input logic rw, input bit full);
        logic [35:0] d [4];
        logic [3:0]  s [4];
        logic [3:0]  w;
        logic [5:0]  ba;
        for (int k = 0; k < 4; k++) begin
            d[k] = 36'({$urandom(), $urandom()});
            s[k] = full ? 4'h0 : 4'($urandom());
            w[k] = !rw && (s[k] !== 4'hF);
            ba   = {a[5:2], a[1:0] + 2'(k)};
            for (int l = 0; l < 4; l++) begin
                if (!rw && !s[k][l]) mem_m[ba][9*l +: 9] = d[k][9*l +: 9];
            end
        end
        u_ctl.burst(a, rw, d, s);
        @(posedge clk);
        #1 chk_s("write_active", {3'h0, !rw}, {3'h0, write_active});
        chk_s("beat_written lo", {2'h0, w[1:0]}, beat_written);
        @(posedge clk);
        #1 chk_s("beat_written hi", {w[3:2], 2'h0}, beat_written);
        chk_s("write_active end", 4'h0, {3'h0, write_active});
        for (int k = 0; k < 4; k++) begin
            ba = {a[5:2], a[1:0] + 2'(k)};
            @(posedge clk);
            rd_addr <= ba;
            @(posedge clk);
            #1 chk_d("rd_data", mem_m[ba], rd_data);
        end
    endtask
    // verdict: single exit of the run
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // watchdog: tests need about 2100 cycles, so this is ample
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end
    // main sequence
    initial begin
        srst    = 1'b1;
        rd_addr = 6'h00;
        mismatches = 0;
        tests_run  = 0;
        void'($urandom(62));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // fill every word so the array holds known data
        for (int i = 0; i < 16; i++) run(6'(4 * i), 1'b0, 1'b1);
        $display("test fill done");
        // random start, random per-beat selects, some read loads to be refused
        for (int i = 0; i < 120; i++) run(6'($urandom()), ($urandom() % 6) == 0, 1'b0);
        $display("test masked bursts done");
        final_report();
    end
endmodule
